// >>> logic/core_tick_timer_cfg.svh
// Constants of the core tick timer: offsets, field positions, resets, counts
`ifndef CORE_TICK_TIMER_CFG_SVH
`define CORE_TICK_TIMER_CFG_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses (address = index * 4)
// ----------------------------------------------------------------
`define TSC_IDX        16'h0008
`define CNT_IDX        16'h0009
`define IRQ_STS_IDX    16'h000A
`define IRQ_MSK_IDX    16'h000B
`define WDOG_IDX       16'h3FF0
`define TSC_ADDR       (`TSC_IDX << 2)
`define CNT_ADDR       (`CNT_IDX << 2)
`define IRQ_STS_ADDR   (`IRQ_STS_IDX << 2)
`define IRQ_MSK_ADDR   (`IRQ_MSK_IDX << 2)
`define WDOG_ADDR      (`WDOG_IDX << 2)

// ----------------------------------------------------------------
// Field positions of timer_status_control, and the watchdog service bit
// ----------------------------------------------------------------
`define F_OVF_FLAG     7
`define F_TICK_FLAG    6
`define F_OVF_IEN      5
`define F_TICK_IEN     4
`define F_OVF_CLR      3
`define F_TICK_CLR     2
`define F_RATE_HI      1
`define F_RATE_LO      0
`define F_WDOG_SVC     0

// ----------------------------------------------------------------
// Sticky event bits, reset values
// ----------------------------------------------------------------
`define EV_OVF         0
`define EV_TICK        1
`define EV_WDOG        2
`define EV_W           3
`define RATE_RESET     2'b11
`define IRQ_RESET      3'b000

// ----------------------------------------------------------------
// Chain layout and timing counts
// ----------------------------------------------------------------
`define CHAIN_W        17
`define CNT_LSB        2
`define CNT_MSB        9
`define OVF_TAP        9
`define TICK_TAP       13
`define POR_CYCLES     4064
`define POR_W          12
`define WDOG_W         3

`endif

// >>> logic/core_tick_timer_pkg.sv
// Types shared by the core tick timer modules
package core_tick_timer_pkg;
`include "core_tick_timer_cfg.svh"

   // Block operating phase
   typedef enum logic [1:0] {S_POR, S_RUN, S_STOP} mode_t;

   // Whole state of the timer top
   typedef struct packed {
      mode_t                mode;       // Operating phase
      logic                 ext_s1;     // External reset sync, first stage
      logic                 ext_s2;     // External reset sync, second stage
      logic                 ovf_flag;   // Counter wrapped
      logic                 tick_flag;  // Periodic tick seen
      logic                 ovf_en;     // Overflow irq enable
      logic                 tick_en;    // Tick irq enable
      logic [1:0]           rate;       // Tick rate select
      logic [`WDOG_W-1:0]   wdog;       // Final divide-by-eight stage
      logic                 wdog_pulse; // Watchdog reset request
      logic [`EV_W-1:0]     irq_sts;    // Sticky events
      logic [`EV_W-1:0]     irq_msk;    // Event mask
      logic                 wr_pend;    // Write data phase pending
      logic [15:0]          wr_addr;    // Address of pending write
      logic [7:0]           rdata;      // Read data for data phase
   } timer_state_t;

endpackage : core_tick_timer_pkg

// >>> logic/chain_if.sv
// Carrier between the timer control and its divider chain
`timescale 1ns/1ps
interface chain_if #(parameter int W = 17);
   logic         clr;    // Clear whole chain
   logic [W-1:0] count;  // Chain value
   logic [W-1:0] carry;  // carry[k]: bits k..0 all ones and clr low

   modport ctl   (output clr, input count, input carry);
   modport chain (input clr, output count, output carry);
endinterface : chain_if

// >>> logic/ripple_chain.sv
// Binary divider chain: prescaler, visible counter and tick stages
`timescale 1ns/1ps
`include "core_tick_timer_cfg.svh"
module ripple_chain
   import core_tick_timer_pkg::*;
#(
   parameter int W = `CHAIN_W
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Chain control and taps
   chain_if.chain   ch
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] count; // Whole chain, bit 0 toggles each clock
   } chain_st_t;

   chain_st_t s_q;  // Registered state
   chain_st_t s_d;  // Next state
   logic      acc;  // Running and of low bits

   // Next state: clear beats counting
   always_comb begin
      s_d = s_q;
      if (ch.clr) begin
         s_d.count = '0;
      end else begin
         s_d.count = s_q.count + 1'b1;
      end
   end

   // Carry taps, one per stage
   always_comb begin
      acc = 1'b1;
      for (int k = 0; k < W; k++) begin
         acc = acc & s_q.count[k];
         ch.carry[k] = acc & ~ch.clr;
      end
   end

   assign ch.count = s_q.count;

   // Register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_chain_clear: assert property (@(posedge clk) disable iff (rst)
      ch.clr |=> s_q.count == '0)
      else $error("chain not cleared");

endmodule : ripple_chain

// >>> logic/core_tick_timer.sv
// Core tick timer: counter, overflow, periodic tick, watchdog, AHB regs
//
// Operation
// - Divide-by-four prescaler feeds 8-bit counter
// - Count register read-only, read leaves count
// - Overflow flag sets on wrap, every 1024
// - Overflow flag with enable requests interrupt
// - Tick flag with enable requests interrupt
// - Tick stages run at clock over 8192
// - Rate field picks 2^14 to 2^17
// - Reset sets both rate bits
// - Overflow clear bit: one clears, reads zero
// - Tick clear bit: one clears, reads zero
// - Reset clears flags and both enables
// - Watchdog divides ticks by eight, resets
// - Writing zero to service clears last stage
// - Power-on counts 4064, clears, then runs
// - External reset clears the whole chain
// - Wait keeps counting, enabled irq wakes
// - Stop clears timer, flags, enables; restarts
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// Guarded, so a second inclusion by the package is harmless
`include "core_tick_timer_cfg.svh"
module core_tick_timer
   import core_tick_timer_pkg::*;
#(
   parameter bit WDOG_ON = 1'b1  // Watchdog fitted
)(
   // Clock and reset
   input  wire  logic        SYS_CLK,
   input  wire  logic        SRST,
   // Device signals
   input  wire  logic        EXT_RST,
   input  wire  logic        WAIT_MODE,
   input  wire  logic        STOP_MODE,
   output logic              POR_HOLD,
   output logic              WDOG_RESET,
   output logic              CPU_IRQ,
   output logic              WAKE_UP,
   output logic              IRQ,
   // AHB-Lite slave
   input  wire  logic        HSEL,
   input  wire  logic [15:0] HADDR,
   input  wire  logic [1:0]  HTRANS,
   input  wire  logic        HWRITE,
   input  wire  logic [2:0]  HSIZE,
   input  wire  logic [31:0] HWDATA,
   input  wire  logic        HREADY,
   output logic [31:0]       HRDATA,
   output logic              HREADYOUT,
   output logic              HRESP
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam timer_state_t ST_RESET = '{
      mode: S_POR, ext_s1: 1'b0, ext_s2: 1'b0, ovf_flag: 1'b0,
      tick_flag: 1'b0, ovf_en: 1'b0, tick_en: 1'b0,
      rate: `RATE_RESET, wdog: '0, wdog_pulse: 1'b0,
      irq_sts: `IRQ_RESET, irq_msk: `IRQ_RESET, wr_pend: 1'b0,
      wr_addr: 16'h0000, rdata: 8'h00};
   localparam logic [`POR_W-1:0] POR_LAST =
      `POR_W'(`POR_CYCLES - 1);

   timer_state_t      s_q;       // Registered state
   timer_state_t      s_d;       // Next state
   logic              live;      // Chain events count now
   logic              ovf_evt;   // Counter wraps this cycle
   logic              tick_evt;  // Selected tick stage fires
   logic              por_done;  // Power-on delay complete
   logic              addr_ok;   // Valid address phase
   logic              wr;        // Write data phase now
   logic [7:0]        wd;        // Write data byte
   logic              svc;       // Watchdog service write
   logic [`WDOG_W-1:0] wbase;    // Watchdog stage after service

   chain_if #(.W(`CHAIN_W)) ch ();

   // ----------------------------------------------------------------
   // Divider chain
   // ----------------------------------------------------------------
   ripple_chain #(.W(`CHAIN_W)) u_chain (
      .clk (SYS_CLK),
      .rst (SRST),
      .ch  (ch)
   );

   // Chain clear: external reset, power-on release, stop
   // The synced pin clears the chain in every phase, power-on too
   always_comb begin
      ch.clr = s_q.ext_s2
             | (s_q.mode == S_STOP)
             | (s_q.mode == S_RUN && STOP_MODE)
             | por_done;
   end

   // ----------------------------------------------------------------
   // Event taps
   // ----------------------------------------------------------------
   // Events only in normal running; held off while the device waits
   // out its power-on or stabilization delay
   always_comb begin
      live     = (s_q.mode == S_RUN) && !STOP_MODE && !s_q.ext_s2;
      ovf_evt  = live && ch.carry[`OVF_TAP];
      tick_evt = live && ch.carry[`TICK_TAP + s_q.rate];
      por_done = (s_q.mode == S_POR)
               && (ch.count[`POR_W-1:0] == POR_LAST);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d            = s_q;
      s_d.wdog_pulse = 1'b0;
      // Two flops for the pin before anything reads it
      s_d.ext_s1     = EXT_RST;
      s_d.ext_s2     = s_q.ext_s1;

      // Address phase capture
      addr_ok     = HSEL && HTRANS[1] && HREADY;
      s_d.wr_pend = addr_ok && HWRITE;
      s_d.wr_addr = HADDR;

      // Write data phase
      wr  = s_q.wr_pend;
      wd  = HWDATA[7:0];
      svc = wr && (s_q.wr_addr == `WDOG_ADDR)
            && !wd[`F_WDOG_SVC];
      if (wr && s_q.wr_addr == `TSC_ADDR) begin
         s_d.ovf_en  = wd[`F_OVF_IEN];
         s_d.tick_en = wd[`F_TICK_IEN];
         s_d.rate    = wd[`F_RATE_HI:`F_RATE_LO];
         if (wd[`F_OVF_CLR]) begin
            s_d.ovf_flag = 1'b0;
         end
         if (wd[`F_TICK_CLR]) begin
            s_d.tick_flag = 1'b0;
         end
      end
      if (wr && s_q.wr_addr == `IRQ_STS_ADDR) begin
         s_d.irq_sts = s_q.irq_sts & ~wd[`EV_W-1:0];
      end
      if (wr && s_q.wr_addr == `IRQ_MSK_ADDR) begin
         s_d.irq_msk = wd[`EV_W-1:0];
      end

      // Hardware sets win over the clears above
      wbase = svc ? '0 : s_q.wdog;
      s_d.wdog = wbase;
      if (ovf_evt) begin
         s_d.ovf_flag         = 1'b1;
         s_d.irq_sts[`EV_OVF] = 1'b1;
      end
      if (tick_evt) begin
         s_d.tick_flag         = 1'b1;
         s_d.irq_sts[`EV_TICK] = 1'b1;
         // Only the last stage is serviced, so a time-out may come
         // as early as seven periods after a service
         if (WDOG_ON) begin
            s_d.wdog = wbase + 1'b1;
            if (&wbase) begin
               s_d.wdog_pulse        = 1'b1;
               s_d.irq_sts[`EV_WDOG] = 1'b1;
            end
         end
      end

      // Operating phase
      unique case (s_q.mode)
         S_POR: begin
            if (por_done) begin
               s_d.mode = S_RUN;
            end
         end
         S_RUN: begin
            if (STOP_MODE) begin
               s_d.mode      = S_STOP;
               s_d.ovf_flag  = 1'b0;
               s_d.tick_flag = 1'b0;
               s_d.ovf_en    = 1'b0;
               s_d.tick_en   = 1'b0;
               s_d.wdog      = '0;
            end
         end
         S_STOP: begin
            // Exit waits out the stabilization delay, then clears
            if (!STOP_MODE) begin
               s_d.mode = S_POR;
            end
         end
      endcase

      // External reset during operation
      if (s_q.ext_s2) begin
         s_d.ovf_flag  = 1'b0;
         s_d.tick_flag = 1'b0;
         s_d.ovf_en    = 1'b0;
         s_d.tick_en   = 1'b0;
         s_d.rate      = `RATE_RESET;
         s_d.wdog      = '0;
         if (s_q.mode == S_STOP) begin
            s_d.mode = S_POR;
         end
      end

      // Read mux, sampled in the address phase
      s_d.rdata = 8'h00;
      if (addr_ok && !HWRITE) begin
         unique case (HADDR)
            `TSC_ADDR: s_d.rdata = {s_d.ovf_flag, s_d.tick_flag,
                                    s_d.ovf_en, s_d.tick_en, 2'b00,
                                    s_d.rate};
            `CNT_ADDR: s_d.rdata =
               ch.count[`CNT_MSB:`CNT_LSB];
            `IRQ_STS_ADDR: s_d.rdata = {5'b00000, s_d.irq_sts};
            `IRQ_MSK_ADDR: s_d.rdata = {5'b00000, s_d.irq_msk};
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   // Register, synchronous reset to constants
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         s_q <= ST_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign CPU_IRQ    = (s_q.ovf_flag & s_q.ovf_en)
                     | (s_q.tick_flag & s_q.tick_en);
   assign WAKE_UP    = WAIT_MODE & CPU_IRQ;
   assign IRQ        = |(s_q.irq_sts & s_q.irq_msk);
   assign POR_HOLD   = (s_q.mode == S_POR);
   assign WDOG_RESET = s_q.wdog_pulse;
   assign HRDATA     = {24'h00_0000, s_q.rdata};
   assign HREADYOUT  = 1'b1;
   assign HRESP      = 1'b0;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   a_prescale_hold: assert property (
      (s_q.mode == S_RUN && !ch.clr && ch.count[1:0] != 2'b11)
      |=> $stable(ch.count[`CNT_MSB:`CNT_LSB]))
      else $error("counter moved between prescaler ends");

   a_count_read: assert property (
      (addr_ok && !HWRITE && HADDR == `CNT_ADDR)
      |=> HRDATA[7:0] == $past(ch.count[`CNT_MSB:`CNT_LSB]))
      else $error("count read mismatch");

   a_ovf_set: assert property (ovf_evt |=> s_q.ovf_flag)
      else $error("overflow flag not set");

   a_ovf_irq: assert property (
      (s_q.ovf_flag && s_q.ovf_en) |-> CPU_IRQ)
      else $error("overflow irq missing");

   a_tick_irq: assert property (
      (s_q.tick_flag && s_q.tick_en)
      |-> (CPU_IRQ && (!WAIT_MODE || WAKE_UP)))
      else $error("tick irq missing");

   a_tick_rate: assert property (
      tick_evt |-> ch.count[`TICK_TAP-1:0] == '1)
      else $error("tick off its stage");

   a_reset_vals: assert property (
      $past(SRST) |-> (s_q.rate == 2'b11 && !s_q.ovf_flag
                       && !s_q.tick_en && !s_q.ovf_en))
      else $error("bad reset values");

   a_ovf_clear: assert property (
      (wr && s_q.wr_addr == `TSC_ADDR && wd[`F_OVF_CLR] && !ovf_evt)
      |=> !s_q.ovf_flag)
      else $error("overflow flag not cleared");

   a_wdog_svc: assert property (
      (svc && !tick_evt) |=> s_q.wdog == '0)
      else $error("watchdog not serviced");

   a_por_release: assert property (
      por_done |=> (s_q.mode == S_RUN && ch.count == '0) ##1
                   ch.count == `CHAIN_W'(1))
      else $error("power-on release wrong");

   a_stop_clear: assert property (
      (s_q.mode == S_RUN && STOP_MODE)
      |=> (!s_q.ovf_en && !s_q.tick_flag && s_q.mode == S_STOP))
      else $error("stop entry did not clear");

   c_overflow: cover property (ovf_evt ##1 CPU_IRQ);
   c_wdog_bite: cover property (s_q.wdog_pulse);
   c_stop_exit: cover property (s_q.mode == S_STOP ##1 s_q.mode == S_POR);
   // Waking the core from a tick, and a pin reset in mid-run
   c_tick_wake: cover property (tick_evt ##1 WAKE_UP);
   c_ext_reset: cover property (s_q.ext_s2 && s_q.mode == S_RUN);

endmodule : core_tick_timer

// >>> tb/core_model.sv
// Processor core model: AHB-Lite master of the timer registers
`timescale 1ns/1ps
module core_model (
   // Clock
   input  wire logic        clk,
   // Bus answer
   input  wire logic [31:0] hrdata,
   input  wire logic        hready,
   // Bus request
   output logic             hsel,
   output logic [15:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   logic [31:0] rd_smp;  // Read data as it stood at the last edge

   // ------------------------------------------------------------
   // Idle bus at time zero
   // ------------------------------------------------------------
   initial begin
      hsel   = 1'b0;
      haddr  = 16'h0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'b010;
      hwdata = 32'h0000_0000;
   end

   // Capture before the edge updates it, so no race with the slave
   always @(posedge clk) begin
      rd_smp <= hrdata;
   end

   // One single word transfer, held until hready is seen high
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      haddr  <= ~a;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      // Released data no longer shows the old value
      hwdata <= ~wd;
      #1;
      rd = rd_smp;
   endtask : xfer
endmodule : core_model

// >>> tb/tb_core_tick_timer.sv
// Self-checking bench of the core tick timer
`timescale 1ns/1ps
`include "core_tick_timer_cfg.svh"
module tb_core_tick_timer;
   import core_tick_timer_pkg::*;
   logic        sys_clk, srst, ext_rst, wait_mode, stop_mode;
   logic        por_hold, wdog_reset, cpu_irq, wake_up, irq;
   logic        hsel, hwrite, hreadyout, hresp;
   logic [15:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, v, c1, c2;
   int          fails, checks, cyc, seed, t0;

   // ------------------------------------------------------------
   // Clock, cycle count, design and core model
   // ------------------------------------------------------------
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;

   core_tick_timer dut_u (.SYS_CLK(sys_clk), .SRST(srst),
      .EXT_RST(ext_rst), .WAIT_MODE(wait_mode), .STOP_MODE(stop_mode),
      .POR_HOLD(por_hold), .WDOG_RESET(wdog_reset), .CPU_IRQ(cpu_irq),
      .WAKE_UP(wake_up), .IRQ(irq), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp));
   core_model core_u (.clk(sys_clk), .hrdata(hrdata), .hready(hreadyout),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   // ------------------------------------------------------------
   // Compare, bus and wait helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic chk_bit(input string what, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %b seen %b", what, e, g);
      end
   endtask : chk_bit
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] x;
      core_u.xfer(1'b1, a, d, x);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      core_u.xfer(1'b0, a, 32'h0000_0000, d);
   endtask : rd
   // Control bits that read back: enables and rate only
   function automatic logic [31:0] exp_ctl(input logic [7:0] w);
      return {24'h00_0000, 2'b00, w[5:4], 2'b00, w[1:0]};
   endfunction : exp_ctl
   // Wait, bounded, until a signal reads high just after an edge
   task automatic wait_hi(ref logic s, output int t);
      int n;
      n = 0;
      @(posedge sys_clk);
      #1;
      while (s !== 1'b1 && n < 40000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 40000) fails++;
      t = cyc;
   endtask : wait_hi
   task automatic wait_por(output int t);
      int n;
      n = 0;
      while (por_hold !== 1'b0 && n < 5000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 5000) fails++;
      t = cyc;
   endtask : wait_por
   // Gap between two events, flag cleared in between
   task automatic period(input logic [7:0] ctl, input logic [7:0] clr,
                         input int e);
      int a, b;
      wr(`WDOG_ADDR, 32'h0000_0000);
      wr(`TSC_ADDR, {24'h00_0000, ctl | clr});
      wait_hi(cpu_irq, a);
      wr(`TSC_ADDR, {24'h00_0000, ctl | clr});
      chk_bit("irq after clear", 1'b0, cpu_irq);
      wait_hi(cpu_irq, b);
      chk("event period", e, b - a);
   endtask : period
   task automatic give_verdict;
      if (fails == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // Watchdog on the whole run
   initial begin
      repeat (80000) @(posedge sys_clk);
      fails++;
      give_verdict;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 52;
      fails = 0;
      checks = 0;
      cyc = 0;
      srst = 1'b1;
      ext_rst = 1'b0;
      wait_mode = 1'b0;
      stop_mode = 1'b0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      t0 = cyc;
      rd(`TSC_ADDR, v);
      chk("ctl after reset", 32'h0000_0003, v);
      chk_bit("por hold", 1'b1, por_hold);
      wait_por(c1);
      chk_bit("por length", 1'b1, (c1 - t0) inside {[4064:4066]});
      // Count steps once per four clocks; writes cannot move it
      wr(`CNT_ADDR, $random(seed));
      rd(`CNT_ADDR, c1);
      repeat (37) @(posedge sys_clk);
      rd(`CNT_ADDR, c2);
      chk("count step", 32'h0000_000A, (c2 - c1) & 32'h0000_00FF);
      rd(16'h0040, v);
      chk("unmapped read", 32'h0000_0000, v);
      // Random control writes, every rate code among them
      for (int i = 0; i < 8; i++) begin
         c1 = $random(seed);
         if (i < 4) c1[1:0] = i[1:0];
         wr(`WDOG_ADDR, 32'h0000_0000);
         wr(`TSC_ADDR, c1);
         rd(`TSC_ADDR, v);
         chk("ctl readback", exp_ctl(c1[7:0]), v & 32'h3F);
      end
      period(8'h20, 8'h08, 1024);
      // Sticky status, mask, write one to clear
      rd(`IRQ_STS_ADDR, v);
      chk_bit("sts overflow", 1'b1, v[0]);
      wr(`IRQ_MSK_ADDR, 32'h0000_0001);
      chk_bit("irq masked in", 1'b1, irq);
      wr(`IRQ_STS_ADDR, 32'h0000_0001);
      chk_bit("irq cleared", 1'b0, irq);
      // Tick at fastest rate, core waiting
      wr(`WDOG_ADDR, 32'h0000_0000);
      @(posedge sys_clk);
      wait_mode <= 1'b1;
      period(8'h10, 8'h04, 16384);
      chk_bit("wake", 1'b1, wake_up);
      // Stop clears timer, flags, enables
      @(posedge sys_clk);
      wait_mode <= 1'b0;
      stop_mode <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(`TSC_ADDR, v);
      chk("ctl in stop", 32'h0000_0000, v);
      rd(`CNT_ADDR, v);
      chk("count in stop", 32'h0000_0000, v);
      @(posedge sys_clk);
      stop_mode <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk_bit("stop delay", 1'b1, por_hold);
      wait_por(c1);
      // External reset in mid-run
      wr(`TSC_ADDR, 32'h0000_0030);
      @(posedge sys_clk);
      ext_rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(`TSC_ADDR, v);
      chk("ctl after ext", 32'h0000_0003, v);
      rd(`CNT_ADDR, v);
      chk_bit("chain cleared", 1'b1, v < 4);
      rd(`IRQ_STS_ADDR, v);
      chk_bit("no watchdog", 1'b0, v[2]);
      chk_bit("watchdog pulse", 1'b0, wdog_reset);
      chk_bit("bus ready", 1'b1, hreadyout);
      chk_bit("bus okay", 1'b0, hresp);
      give_verdict;
   end
endmodule : tb_core_tick_timer
